// ===== swv_pkg.sv
// Constants and types shared by the scratchpad write, verify and copy block
package swv_pkg;

  // Command codes
  localparam logic [7:0]  CMD_WRITE_SP     = 8'h0F;
  localparam logic [7:0]  CMD_READ_SP      = 8'hAA;
  localparam logic [7:0]  CMD_COPY_SP      = 8'h99;

  // Geometry
  localparam int          ADDR_W           = 16;
  localparam int          OFFS_W           = 5;
  localparam int          SP_BYTES         = 32;
  localparam int          PW_BITS          = 64;
  localparam int          AUTH_BYTES       = 3;
  localparam logic [4:0]  END_OFFSET_FULL  = 5'h1F;

  // Status byte layout
  localparam int          ES_PF_BIT        = 5;
  localparam int          ES_ZERO_BIT      = 6;
  localparam int          ES_AA_BIT        = 7;

  // CRC-16, x16+x15+x2+1, reflected form for LSB-first shifting
  localparam logic [15:0] CRC_POLY_REV     = 16'hA001;
  localparam logic [15:0] CRC_INIT         = 16'h0000;

  // Transmit patterns
  localparam logic [15:0] TX_ALL_ONES      = 16'hFFFF;
  localparam logic [15:0] TX_ALTERNATE     = 16'h5555;
  localparam logic [7:0]  TX_FILL          = 8'hFF;

  // Register pages, refused as copy targets during a mission
  localparam logic [15:0] REG_PAGE_FIRST   = 16'h0200;
  localparam logic [15:0] REG_PAGE_LAST    = 16'h023F;

  // Timing
  localparam int          CLK_PERIOD_PS    = 50000;
  localparam int          COPY_BYTE_NS     = 2;
  localparam int          COPY_BYTE_CYCLES = (COPY_BYTE_NS * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    ST_DEAD,
    ST_CMD,
    ST_WADDR,
    ST_WDATA,
    ST_WCRC_LD,
    ST_RD,
    ST_RCRC_LD,
    ST_CRC,
    ST_ONES,
    ST_CAUTH,
    ST_CPW,
    ST_CHECK,
    ST_COPY,
    ST_ALT
  } swv_state_t;

endpackage

// ===== swv_crc16.sv
// Bit-serial CRC-16 generator, LSB first
`timescale 1ns/1ps
`default_nettype none
module swv_crc16
  import swv_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        din,
  output logic      [15:0] crc
);

  logic        fb;
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  always_comb
  begin
    fb    = din ^ crc_q[0];
    crc_d = {1'b0, crc_q[15:1]} ^ (fb ? CRC_POLY_REV : CRC_INIT);
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn || clr)
      crc_q <= CRC_INIT;
    else if (en)
      crc_q <= crc_d;
  end

  assign crc = crc_q;

endmodule
`default_nettype wire

// ===== swv_scratchpad.sv
// Scratchpad write, verify and password-checked copy command engine
`timescale 1ns/1ps
`default_nettype none
module swv_scratchpad
  import swv_pkg::*;
#(
  parameter int COPY_CYCLES = swv_pkg::COPY_BYTE_CYCLES
)
(
  input  wire logic                             mclk,
  input  wire logic                             rstn,
  input  wire logic                             bus_reset,
  input  wire logic                             wr_slot,
  input  wire logic                             wr_bit,
  input  wire logic                             rd_slot,
  output logic                                  tx_bit,
  output logic                                  tx_enable,
  input  wire logic                             od_enter,
  input  wire logic                             od_exit,
  output logic                                  overdrive_select,
  input  wire logic                             mission_active,
  input  wire logic                             pw_check_enable,
  input  wire logic [swv_pkg::PW_BITS-1:0]      full_password,
  input  wire logic                             mem_internal_busy,
  output logic                                  mem_wr_en,
  output logic      [swv_pkg::ADDR_W-1:0]       mem_wr_addr,
  output logic      [7:0]                       mem_wr_data,
  output logic                                  copy_busy,
  output logic      [7:0]                       target_address_low,
  output logic      [7:0]                       target_address_high,
  output logic      [7:0]                       ending_offset_status
);
  import swv_pkg::*;

  localparam logic [6:0] PW_LAST   = 7'(PW_BITS - 1);
  localparam logic [6:0] AUTH_LAST = 7'(AUTH_BYTES - 1);
  localparam logic [8:0] CRC_LAST  = 9'd15;
  localparam logic [5:0] BYTE_TA1  = 6'd0;
  localparam logic [5:0] BYTE_TA2  = 6'd1;
  localparam logic [5:0] BYTE_ES   = 6'd2;
  localparam int         WAIT_W    = $clog2(COPY_CYCLES + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(COPY_CYCLES - 1);

  swv_state_t          state_q;
  logic [8:0]          cnt_q;
  logic [2:0]          bit_q;
  logic [7:0]          rx_sr_q;
  logic [7:0]          ta_lo_q;
  logic [7:0]          ta_hi_q;
  logic [OFFS_W-1:0]   end_off_q;
  logic [OFFS_W-1:0]   ptr_q;
  logic                pf_q;
  logic                aa_q;
  logic [7:0]          sp_q [SP_BYTES];
  logic [15:0]         tx_sr_q;
  logic [23:0]         auth_q;
  logic [PW_BITS-1:0]  pw_sr_q;
  logic [WAIT_W-1:0]   wait_q;
  logic                od_q;
  logic                mem_en_q;
  logic [ADDR_W-1:0]   mem_addr_q;
  logic [7:0]          mem_data_q;

  logic [7:0]          rx_byte;
  logic [7:0]          es_byte;
  logic                rx_state;
  logic                byte_done;
  logic                rd_byte_end;
  logic                reset_taken;
  logic                pw_bad;
  logic                reg_page;
  logic                copy_ok;
  logic                copy_step;
  logic [OFFS_W-1:0]   ptr_next;
  logic [15:0]         crc;
  logic                crc_en;
  logic                crc_din;

  assign rx_byte     = {wr_bit, rx_sr_q[7:1]};
  assign es_byte     = {aa_q, 1'b0, pf_q, end_off_q};
  assign rx_state    = (state_q == ST_CMD) || (state_q == ST_WADDR) || (state_q == ST_WDATA)
                    || (state_q == ST_CAUTH) || (state_q == ST_CPW);
  assign byte_done   = wr_slot && rx_state && (bit_q == 3'd7);
  assign rd_byte_end = rd_slot && (state_q == ST_RD) && (cnt_q[2:0] == 3'd7);
  assign reset_taken = bus_reset && (state_q != ST_COPY);
  assign ptr_next    = ptr_q + 5'd1;
  assign pw_bad      = pw_check_enable && (pw_sr_q != full_password);
  assign reg_page    = ({ta_hi_q, ta_lo_q} >= REG_PAGE_FIRST) && ({ta_hi_q, ta_lo_q} <= REG_PAGE_LAST);
  // Data and calibration pages fall outside the register range, so they stay open
  assign copy_ok     = (auth_q == {es_byte, ta_hi_q, ta_lo_q})
                    && (end_off_q == END_OFFSET_FULL)
                    && !(mission_active && reg_page);
  // Sampling owns the memory port while it is busy; copy just waits a turn
  assign copy_step   = (state_q == ST_COPY) && (wait_q == WAIT_LAST) && !mem_internal_busy;

  // CRC covers received bits in command and write phases and sent bits in the read phase
  assign crc_en  = (wr_slot && ((state_q == ST_CMD) || (state_q == ST_WADDR) || (state_q == ST_WDATA)))
                || (rd_slot && (state_q == ST_RD));
  assign crc_din = (state_q == ST_RD) ? tx_sr_q[0] : wr_bit;

  swv_crc16 u_crc (
    .mclk (mclk),
    .rstn (rstn),
    .clr  (reset_taken),
    .en   (crc_en),
    .din  (crc_din),
    .crc  (crc)
  );

  // Sequencer
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q <= ST_DEAD;
      cnt_q   <= '0;
    end
    else if (reset_taken)
    begin
      state_q <= ST_CMD;
      cnt_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_DEAD, ST_ONES, ST_ALT: ;
        ST_CMD:
          if (byte_done)
          begin
            cnt_q <= '0;
            if (rx_byte == CMD_WRITE_SP)
              state_q <= ST_WADDR;
            else if (rx_byte == CMD_READ_SP)
              state_q <= ST_RD;
            else if (rx_byte == CMD_COPY_SP)
              state_q <= ST_CAUTH;
            else
              state_q <= ST_DEAD;
          end
        ST_WADDR:
          if (byte_done)
          begin
            cnt_q <= cnt_q + 9'd1;
            if (cnt_q[0])
              state_q <= ST_WDATA;
          end
        ST_WDATA:
          if (byte_done && (ptr_q == END_OFFSET_FULL))
            state_q <= ST_WCRC_LD;
        ST_WCRC_LD, ST_RCRC_LD:
        begin
          cnt_q   <= '0;
          state_q <= ST_CRC;
        end
        ST_RD:
        begin
          if (rd_slot)
            cnt_q <= cnt_q + 9'd1;
          if (rd_byte_end && (cnt_q[8:3] > BYTE_ES) && (ptr_q == END_OFFSET_FULL))
            state_q <= ST_RCRC_LD;
        end
        ST_CRC:
          if (rd_slot)
          begin
            cnt_q <= cnt_q + 9'd1;
            if (cnt_q == CRC_LAST)
              state_q <= ST_ONES;
          end
        ST_CAUTH:
          if (byte_done)
          begin
            cnt_q <= (cnt_q[6:0] == AUTH_LAST) ? 9'd0 : cnt_q + 9'd1;
            if (cnt_q[6:0] == AUTH_LAST)
              state_q <= ST_CPW;
          end
        ST_CPW:
          if (wr_slot)
          begin
            cnt_q <= cnt_q + 9'd1;
            if (cnt_q[6:0] == PW_LAST)
              state_q <= ST_CHECK;
          end
        ST_CHECK:
          if (pw_bad || !copy_ok)
            state_q <= ST_DEAD;
          else
            state_q <= ST_COPY;
        ST_COPY:
          if (copy_step && (ptr_q == end_off_q))
            state_q <= ST_ALT;
      endcase
    end
  end

  // Receive bit position; 64 password bits keep byte alignment
  always_ff @(posedge mclk)
  begin
    if (!rstn || reset_taken)
      bit_q <= '0;
    else if (wr_slot && rx_state)
      bit_q <= bit_q + 3'd1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      rx_sr_q <= '0;
    else if (wr_slot && rx_state)
      rx_sr_q <= rx_byte;
  end

  // Address registers and status byte
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ta_lo_q   <= '0;
      ta_hi_q   <= '0;
      end_off_q <= '0;
      pf_q      <= 1'b0;
      aa_q      <= 1'b0;
    end
    else
    begin
      if (reset_taken && (state_q == ST_WDATA) && (bit_q != 3'd0))
        pf_q <= 1'b1;
      if (byte_done && (state_q == ST_CMD) && (rx_byte == CMD_WRITE_SP))
      begin
        aa_q <= 1'b0;
        pf_q <= 1'b0;
      end
      if (byte_done && (state_q == ST_WADDR))
      begin
        if (cnt_q[0])
          ta_hi_q <= rx_byte;
        else
          ta_lo_q <= rx_byte;
      end
      if (byte_done && (state_q == ST_WDATA))
        end_off_q <= ptr_q;
      if ((state_q == ST_CHECK) && !pw_bad && copy_ok)
        aa_q <= 1'b1;
    end
  end

  // Scratchpad pointer shared by write, read and copy
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      ptr_q <= '0;
    else if (byte_done && (state_q == ST_WADDR) && !cnt_q[0])
      ptr_q <= rx_byte[OFFS_W-1:0];
    else if (byte_done && (state_q == ST_WDATA))
      ptr_q <= ptr_next;
    else if (byte_done && (state_q == ST_CMD) && (rx_byte == CMD_READ_SP))
      ptr_q <= ta_lo_q[OFFS_W-1:0];
    else if (rd_byte_end && (cnt_q[8:3] > BYTE_ES))
      ptr_q <= ptr_next;
    else if (state_q == ST_CHECK)
      ptr_q <= ta_lo_q[OFFS_W-1:0];
    else if (copy_step)
      ptr_q <= ptr_next;
  end

  // Scratchpad storage; a partial trailing byte never reaches here
  always_ff @(posedge mclk)
  begin
    if (byte_done && (state_q == ST_WDATA))
      sp_q[ptr_q] <= rx_byte;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      auth_q <= '0;
    else if (byte_done && (state_q == ST_CAUTH))
      auth_q <= {rx_byte, auth_q[23:8]};
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      pw_sr_q <= '0;
    else if (wr_slot && (state_q == ST_CPW))
      pw_sr_q <= {wr_bit, pw_sr_q[PW_BITS-1:1]};
  end

  // Transmit shifter: ones fill in behind, so the CRC tail runs into ones by itself
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      tx_sr_q <= TX_ALL_ONES;
    else if (byte_done && (state_q == ST_CMD) && (rx_byte == CMD_READ_SP))
      tx_sr_q <= {TX_FILL, ta_lo_q};
    else if (rd_byte_end)
    begin
      if (cnt_q[8:3] == BYTE_TA1)
        tx_sr_q <= {TX_FILL, ta_hi_q};
      else if (cnt_q[8:3] == BYTE_TA2)
        tx_sr_q <= {TX_FILL, es_byte};
      else if (cnt_q[8:3] == BYTE_ES)
        tx_sr_q <= {TX_FILL, sp_q[ptr_q]};
      else
        tx_sr_q <= {TX_FILL, sp_q[ptr_next]};
    end
    else if ((state_q == ST_WCRC_LD) || (state_q == ST_RCRC_LD))
      tx_sr_q <= ~crc;
    else if (copy_step && (ptr_q == end_off_q))
      tx_sr_q <= TX_ALTERNATE;
    else if (rd_slot && (state_q == ST_ALT))
      tx_sr_q <= {tx_sr_q[0], tx_sr_q[15:1]};
    else if (rd_slot)
      tx_sr_q <= {1'b1, tx_sr_q[15:1]};
  end

  // Copy pacing: one byte per byte time, longer if sampling holds the port
  always_ff @(posedge mclk)
  begin
    if (!rstn || (state_q != ST_COPY) || copy_step)
      wait_q <= '0;
    else if (wait_q != WAIT_LAST)
      wait_q <= wait_q + WAIT_W'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      mem_en_q   <= 1'b0;
      mem_addr_q <= '0;
      mem_data_q <= '0;
    end
    else
    begin
      mem_en_q <= copy_step;
      if (copy_step)
      begin
        mem_addr_q <= {ta_hi_q, ta_lo_q[7:OFFS_W], ptr_q};
        mem_data_q <= sp_q[ptr_q];
      end
    end
  end

  // Speed selection, standard after power-up
  always_ff @(posedge mclk)
  begin
    if (!rstn || (od_exit && !od_enter))
      od_q <= 1'b0;
    else if (od_enter)
      od_q <= 1'b1;
  end

  assign tx_bit               = tx_sr_q[0];
  // Bus released in every receive state and after a failed check
  assign tx_enable            = (state_q == ST_RD) || (state_q == ST_CRC) || (state_q == ST_ONES)
                             || (state_q == ST_ALT);
  assign overdrive_select     = od_q;
  assign mem_wr_en            = mem_en_q;
  assign mem_wr_addr          = mem_addr_q;
  assign mem_wr_data          = mem_data_q;
  assign copy_busy            = (state_q == ST_COPY) || (state_q == ST_CHECK);
  assign target_address_low   = ta_lo_q;
  assign target_address_high  = ta_hi_q;
  assign ending_offset_status = es_byte;

endmodule
`default_nettype wire

// ===== swv_scratchpad_properties.sv
// Port-level assertions for the scratchpad write, verify and copy engine
`timescale 1ns/1ps
`default_nettype none
module swv_scratchpad_properties
  import swv_pkg::*;
#(
  parameter int COPY_CYCLES = 2
)
(
  input wire logic                         mclk,
  input wire logic                         rstn,
  input wire logic                         bus_reset,
  input wire logic                         wr_slot,
  input wire logic                         wr_bit,
  input wire logic                         rd_slot,
  input wire logic                         tx_bit,
  input wire logic                         tx_enable,
  input wire logic                         od_enter,
  input wire logic                         od_exit,
  input wire logic                         overdrive_select,
  input wire logic                         mission_active,
  input wire logic                         pw_check_enable,
  input wire logic [swv_pkg::PW_BITS-1:0]  full_password,
  input wire logic                         mem_internal_busy,
  input wire logic                         mem_wr_en,
  input wire logic [swv_pkg::ADDR_W-1:0]   mem_wr_addr,
  input wire logic [7:0]                   mem_wr_data,
  input wire logic                         copy_busy,
  input wire logic [7:0]                   target_address_low,
  input wire logic [7:0]                   target_address_high,
  input wire logic [7:0]                   ending_offset_status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_zero6; ending_offset_status[ES_ZERO_BIT] == 1'b0; endproperty
  a_zero6: assert property (p_zero6) else $error("status bit 6 set");
  property p_full; mem_wr_en |-> ending_offset_status[4:0] == END_OFFSET_FULL; endproperty
  a_full: assert property (p_full) else $error("copy with short ending offset");
  property p_aa_wr; mem_wr_en |-> ending_offset_status[ES_AA_BIT]; endproperty
  a_aa_wr: assert property (p_aa_wr) else $error("copy write without accept flag");
  property p_aa_rise; $rose(ending_offset_status[ES_AA_BIT]) |-> copy_busy; endproperty
  a_aa_rise: assert property (p_aa_rise) else $error("accept flag outside copy");
  property p_stall; mem_internal_busy |=> !mem_wr_en; endproperty
  a_stall: assert property (p_stall) else $error("copy write while memory owned");
  property p_regpg;
    mem_wr_en && mission_active |-> !(mem_wr_addr inside {[REG_PAGE_FIRST:REG_PAGE_LAST]});
  endproperty
  a_regpg: assert property (p_regpg) else $error("register page written in mission");
  property p_quiet; copy_busy |-> !tx_enable; endproperty
  a_quiet: assert property (p_quiet) else $error("bus driven during copy");
  property p_alt; $fell(copy_busy) && mem_wr_en |-> tx_enable && tx_bit; endproperty
  a_alt: assert property (p_alt) else $error("no alternating pattern after copy");
  property p_bound; $rose(copy_busy) |-> ##[1:1000] !copy_busy; endproperty
  a_bound: assert property (p_bound) else $error("copy never ends");
  property p_od_set; od_enter |=> overdrive_select; endproperty
  a_od_set: assert property (p_od_set) else $error("overdrive not set");
  property p_od_clr; od_exit && !od_enter |=> !overdrive_select; endproperty
  a_od_clr: assert property (p_od_clr) else $error("overdrive not cleared");
  property p_rst; $rose(rstn) |-> !overdrive_select && !tx_enable && ending_offset_status == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");

  c_copy: cover property (mem_wr_en);
  c_rst_in_copy: cover property (bus_reset && copy_busy);
  c_partial: cover property (ending_offset_status[ES_PF_BIT]);
endmodule

bind swv_scratchpad swv_scratchpad_properties #(.COPY_CYCLES(COPY_CYCLES)) swv_scratchpad_properties_inst (
  .mclk(mclk), .rstn(rstn), .bus_reset(bus_reset), .wr_slot(wr_slot), .wr_bit(wr_bit),
  .rd_slot(rd_slot), .tx_bit(tx_bit), .tx_enable(tx_enable), .od_enter(od_enter), .od_exit(od_exit),
  .overdrive_select(overdrive_select), .mission_active(mission_active), .pw_check_enable(pw_check_enable),
  .full_password(full_password), .mem_internal_busy(mem_internal_busy), .mem_wr_en(mem_wr_en),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .copy_busy(copy_busy),
  .target_address_low(target_address_low), .target_address_high(target_address_high),
  .ending_offset_status(ending_offset_status));
`default_nettype wire

// ===== swv_master_model.sv
// Bus master model: write, read and reset slots on the serial link
`timescale 1ns/1ps
`default_nettype none
module swv_master_model
(
  input  wire logic mclk,
  input  wire logic tx_bit,
  output logic      bus_reset,
  output logic      wr_slot,
  output logic      wr_bit,
  output logic      rd_slot
);
  initial
  begin
    bus_reset = 1'b0;
    wr_slot   = 1'b0;
    wr_bit    = 1'b1;
    rd_slot   = 1'b0;
  end
  // Slots start five cycles apart, much tighter than a real bus
  task automatic gap();
    repeat (3) @(negedge mclk);
  endtask
  task automatic reset_pulse();
    @(negedge mclk) bus_reset = 1'b1;
    @(negedge mclk) bus_reset = 1'b0;
    gap();
  endtask
  task automatic wbit(input logic b);
    @(negedge mclk) wr_slot = 1'b1;
    wr_bit = b;
    @(negedge mclk) wr_slot = 1'b0;
    wr_bit = ~b; // Released line must not keep showing the bit
    gap();
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) wbit(b[i]);
  endtask
  task automatic send_pw(input logic [63:0] p);
    for (int i = 0; i < 64; i++) wbit(p[i]);
  endtask
  task automatic recv_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk) rd_slot = 1'b1;
      b[i] = tx_bit; // Bit stands from the previous slot, so take it here
      @(negedge mclk) rd_slot = 1'b0;
      gap();
    end
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the scratchpad write, verify and copy engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swv_pkg::*;
  localparam int          CC = 2;
  localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
  logic        mclk, rstn, bus_reset, wr_slot, wr_bit, rd_slot, tx_bit, tx_enable;
  logic        od_enter, od_exit, overdrive_select, mission_active, pw_check_enable;
  logic        mem_internal_busy, mem_wr_en, copy_busy;
  logic [63:0] full_password;
  logic [15:0] mem_wr_addr, crc;
  logic [7:0]  mem_wr_data, target_address_low, target_address_high, ending_offset_status;
  logic [7:0]  sp [32];
  logic [15:0] aq [$];
  logic [7:0]  wq [$];
  int          n_errors, n_checks;

  swv_scratchpad #(.COPY_CYCLES(CC)) swv_scratchpad_inst (
    .mclk(mclk), .rstn(rstn), .bus_reset(bus_reset), .wr_slot(wr_slot), .wr_bit(wr_bit),
    .rd_slot(rd_slot), .tx_bit(tx_bit), .tx_enable(tx_enable), .od_enter(od_enter), .od_exit(od_exit),
    .overdrive_select(overdrive_select), .mission_active(mission_active), .pw_check_enable(pw_check_enable),
    .full_password(full_password), .mem_internal_busy(mem_internal_busy), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .copy_busy(copy_busy),
    .target_address_low(target_address_low), .target_address_high(target_address_high),
    .ending_offset_status(ending_offset_status));
  swv_master_model swv_master_model_inst (
    .mclk(mclk), .tx_bit(tx_bit), .bus_reset(bus_reset), .wr_slot(wr_slot), .wr_bit(wr_bit), .rd_slot(rd_slot));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk)
    if (mem_wr_en === 1'b1)
    begin
      aq.push_back(mem_wr_addr);
      wq.push_back(mem_wr_data);
    end

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      crc = (crc >> 1) ^ ((crc[0] ^ d[i]) ? 16'hA001 : 16'h0000);
    swv_master_model_inst.send_byte(d);
  endtask
  task automatic rx(input string nm, input logic [7:0] e);
    logic [7:0] d;
    swv_master_model_inst.recv_byte(d);
    for (int i = 0; i < 8; i++)
      crc = (crc >> 1) ^ ((crc[0] ^ d[i]) ? 16'hA001 : 16'h0000);
    chk(nm, d, e);
  endtask
  task automatic wr(input logic [15:0] a, input int n, input bit rd);
    logic [15:0] c;
    swv_master_model_inst.reset_pulse();
    crc = 16'h0000;
    tx(CMD_WRITE_SP);
    tx(a[7:0]);
    tx(a[15:8]);
    for (int i = 0; i < n; i++)
    begin
      sp[a[4:0] + i] = 8'(i * 37 + 5);
      tx(sp[a[4:0] + i]);
    end
    c = ~crc;
    if (rd)
    begin
      rx("wcrc_lo", c[7:0]);
      rx("wcrc_hi", c[15:8]);
    end
  endtask
  task automatic rdv(input logic [15:0] a, input logic [7:0] e);
    logic [15:0] c;
    swv_master_model_inst.reset_pulse();
    crc = 16'h0000;
    tx(CMD_READ_SP);
    rx("ta1", a[7:0]);
    rx("ta2", a[15:8]);
    rx("es", e);
    for (int i = a[4:0]; i < 32; i++)
      rx("spd", sp[i]);
    c = ~crc;
    rx("rcrc_lo", c[7:0]);
    rx("rcrc_hi", c[15:8]);
    rx("ones", 8'hFF);
  endtask
  task automatic cp(input logic [15:0] a, input logic [7:0] e, input logic [63:0] p);
    swv_master_model_inst.reset_pulse();
    tx(CMD_COPY_SP);
    tx(a[7:0]);
    tx(a[15:8]);
    tx(e);
    swv_master_model_inst.send_pw(p);
  endtask
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (copy_busy !== v && k < 2000)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 2000)
    begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic chk_q(input logic [15:0] a, input int n);
    // The last write pulse comes in the first cycle after copy_busy falls
    repeat (2) @(negedge mclk);
    chk("nwr", aq.size(), n);
    for (int i = 0; i < aq.size(); i++)
    begin
      chk("waddr", aq[i], a + 16'(i));
      chk("wdata", wq[i], sp[a[4:0] + i]);
    end
    aq.delete();
    wq.delete();
  endtask

  initial
  begin
    n_errors = 0;
    n_checks = 0;
    rstn = 1'b0;
    od_enter = 1'b0;
    od_exit = 1'b0;
    mission_active = 1'b1;
    pw_check_enable = 1'b1;
    full_password = PW;
    mem_internal_busy = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    chk("es_rst", ending_offset_status, 8'h00);
    chk("od_rst", overdrive_select, 1'b0);
    @(negedge mclk) od_enter = 1'b1;
    @(negedge mclk) od_enter = 1'b0;
    chk("od_set", overdrive_select, 1'b1);
    @(negedge mclk) od_exit = 1'b1;
    @(negedge mclk) od_exit = 1'b0;
    chk("od_clr", overdrive_select, 1'b0);
    wr(16'h013C, 4, 1'b1);
    chk("ta1", target_address_low, 8'h3C);
    chk("ta2", target_address_high, 8'h01);
    chk("es_w", ending_offset_status, 8'h1F);
    rdv(16'h013C, 8'h1F);
    // Memory held by sampling so the copy must wait
    mem_internal_busy = 1'b1;
    cp(16'h013C, 8'h1F, PW);
    wait_busy(1'b1);
    swv_master_model_inst.reset_pulse();
    chk("stall", aq.size(), 0);
    mem_internal_busy = 1'b0;
    wait_busy(1'b0);
    chk_q(16'h013C, 4);
    chk("aa", ending_offset_status, 8'h9F);
    rx("alt", 8'h55);
    wr(16'h001E, 1, 1'b0);
    repeat (3) swv_master_model_inst.wbit(1'b0);
    swv_master_model_inst.reset_pulse();
    chk("es_pf", ending_offset_status, 8'h3E);
    rdv(16'h001E, 8'h3E);
    cp(16'h001E, 8'h3E, ~PW);
    repeat (20) @(negedge mclk);
    chk("bpw_tx", tx_enable, 1'b0);
    chk_q(16'h001E, 0);
    cp(16'h001E, 8'h3E, PW);
    repeat (20) @(negedge mclk);
    chk_q(16'h001E, 0);
    chk("aa_off", ending_offset_status[ES_AA_BIT], 1'b0);
    wr(16'h0200, 32, 1'b1);
    cp(16'h0200, 8'h1F, PW);
    repeat (20) @(negedge mclk);
    chk_q(16'h0200, 0);
    chk("aa_mis", ending_offset_status, 8'h1F);
    mission_active = 1'b0;
    pw_check_enable = 1'b0;
    cp(16'h0200, 8'h1F, ~PW);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk_q(16'h0200, 32);
    chk("aa_reg", ending_offset_status, 8'h9F);
    test_done();
  end
endmodule
`default_nettype wire
